// ===== bench/dli_lamp_watch.sv
// ----------------------------------------------------------------
// Lamp observer: measures how long each lamp holds a level
// ----------------------------------------------------------------
module dli_lamp_watch (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [2:0] lamp,
  output logic [2:0][15:0] run_q,
  output logic [2:0][15:0] age_q
);
  // Lamp levels at the previous edge
  logic [2:0] prev_q;

  // Run length is latched on each change, so a blink shows its half period
  always_ff @(posedge mclk)
  begin
    prev_q <= lamp;
    for (int i = 0; i < 3; i++)
    begin
      if (rst)
      begin
        run_q[i] <= 16'h0000;
        age_q[i] <= 16'h0000;
      end
      else if (lamp[i] !== prev_q[i])
      begin
        run_q[i] <= age_q[i];
        age_q[i] <= 16'h0001;
      end
      else
      begin
        // Steady lamp: age keeps growing
        age_q[i] <= age_q[i] + 16'h0001;
      end
    end
  end
endmodule

// ===== bench/dli_top_tb.sv
module dli_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  localparam int SLOW = 8; // Short slow half period keeps the run brief
  localparam int FAST = 3; // Short fast half period
  localparam int LIMIT = 20000; // Hang ceiling in cycles
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [3:0] amber_lamp;
  logic [3:0] green_lamp;
  logic [2:0] lamp; // Identify, amber, green
  logic [2:0][15:0] run;
  logic [2:0][15:0] age;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  // 40 MHz clock
  always #12.5 mclk = ~mclk;

  dli_top #(.SLOW_HALF(SLOW), .FAST_HALF(FAST)) DUT (
    .mclk(mclk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .amber_progress_lamp_q(amber_lamp),
    .green_progress_lamp_q(green_lamp),
    .status_green_q(lamp[0]),
    .status_amber_q(lamp[1]),
    .chassis_identify_lamp_q(lamp[2])
  );

  dli_lamp_watch lw (
    .mclk(mclk),
    .rst(rst),
    .lamp(lamp),
    .run_q(run),
    .age_q(age)
  );

  // ----------------------------------------------------------------
  // Report and checks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      close_out();
    end
  end

  // Single value compare
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge mclk);
    // No local limit: only the hang guard ends a stalled wait
    while (avs_waitrequest !== 1'b0)
      @(posedge mclk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Write, then let lamps and state settle
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    xfer(1'b1, a, d, be, q);
    repeat (4) @(posedge mclk);
  endtask

  // Read and compare the masked word
  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, 4'hf, q);
    cmp(q & m, e);
  endtask

  // Progress lamps as one byte, lamp 7 on the left
  task automatic lmp(input logic [7:0] e);
    cmp({24'h00_0000, amber_lamp, green_lamp}, {24'h00_0000, e});
  endtask

  // Last measured run of a lamp
  task automatic blink(input int idx, input int half);
    repeat (6 * SLOW) @(posedge mclk);
    cmp(32'(run[idx]), half);
  endtask

  // Lamp steady at a level for a long stretch
  task automatic solid(input int idx, input logic lvl);
    repeat (6 * SLOW) @(posedge mclk);
    cmp({30'h0000_0000, age[idx] >= 16'h0028, lamp[idx]}, {30'h0000_0000, 1'b1, lvl});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    // Reset state: all dark, status off
    lmp(8'h00);
    rd(dli_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0000_0001);
    rd(4'h2, 32'hffff_ffff, 32'h0000_0000);
    // Walking one over every lamp
    for (int i = 0; i < 8; i++)
    begin
      wr(dli_pkg::ADDR_CODE, 32'h0000_0001 << i, 4'hf);
      lmp(8'h01 << i);
    end
    wr(dli_pkg::ADDR_CODE, 32'h0000_00ac, 4'hf);
    lmp(8'hac);
    // Ignored writes must not disturb the shown code
    wr(4'h2, 32'h0000_00b5, 4'hf);
    wr(dli_pkg::ADDR_CODE, 32'h0000_0055, 4'he);
    repeat (60) @(posedge mclk);
    lmp(8'hac);
    rd(dli_pkg::ADDR_CODE, 32'h0000_00ff, 32'h0000_00ac);
    // Healthy system
    wr(dli_pkg::ADDR_FLT, 32'h8000_0000, 4'hf);
    rd(dli_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0000_0022);
    solid(0, 1'b1);
    // Each degraded source
    for (int b = 24; b < 28; b++)
    begin
      wr(dli_pkg::ADDR_FLT, 32'h8000_0000 | (32'h0000_0001 << b), 4'hf);
      rd(dli_pkg::ADDR_STAT, 32'h0000_00df, 32'h0000_0004);
    end
    blink(0, SLOW);
    // Each non-fatal alarm, with degraded also set
    for (int b = 0; b < 6; b++)
    begin
      wr(dli_pkg::ADDR_FLT, 32'h8100_0000 | (32'h0000_0001 << b), 4'hf);
      rd(dli_pkg::ADDR_STAT, 32'h0000_00bf, 32'h0000_0008);
    end
    blink(1, SLOW);
    solid(0, 1'b0);
    // Each fatal alarm, with lesser conditions also set
    for (int b = 8; b < 21; b++)
    begin
      wr(dli_pkg::ADDR_FLT, 32'h8100_0001 | (32'h0000_0001 << b), 4'hf);
      rd(dli_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0000_0050);
    end
    solid(1, 1'b1);
    // Controller memory and image failures
    wr(dli_pkg::ADDR_FLT, 32'h8000_0000, 4'hf);
    for (int m = 1; m < 3; m++)
    begin
      wr(dli_pkg::ADDR_MGMT, 32'h0000_0001 << m, 4'hf);
      rd(dli_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0000_00d0);
    end
    solid(2, 1'b1);
    // Bootloader stage: degraded plus fast identify blink
    wr(dli_pkg::ADDR_MGMT, 32'h0000_0001, 4'hf);
    rd(dli_pkg::ADDR_STAT, 32'h0000_005f, 32'h0000_0004);
    blink(2, FAST);
    rd(dli_pkg::ADDR_MGMT, 32'hffff_ffff, 32'h0000_0001);
    // Powered down; status word is read-only
    wr(dli_pkg::ADDR_MGMT, 32'h0000_0000, 4'hf);
    // Top lane only: healthy bit clears, lane 0 keeps its zero
    wr(dli_pkg::ADDR_FLT, 32'h0000_0001, 4'h8);
    rd(dli_pkg::ADDR_FLT, 32'hffff_ffff, 32'h0000_0000);
    wr(dli_pkg::ADDR_FLT, 32'h0000_0000, 4'hf);
    wr(dli_pkg::ADDR_STAT, 32'hffff_ffff, 4'hf);
    rd(dli_pkg::ADDR_STAT, 32'hffff_ffff, 32'h0000_0001);
    lmp(8'hac);
    close_out();
  end
endmodule

// ===== rtl/dli_blink_div.sv
// Free-running blink divider: toggles a 50 percent square wave
module dli_blink_div #(
  parameter int HALF_CYC = 20_000_000
) (
  input wire logic mclk,
  input wire logic rst,
  output logic wave_q
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (HALF_CYC < 2) begin : g_chk
    $error("dli_blink_div: HALF_CYC too small");
  end

  logic [31:0] cnt_q; // Half-period counter

  // Count half periods, flip the wave at each wrap
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cnt_q <= 32'h0000_0000;
      wave_q <= 1'b0;
    end
    else if (cnt_q == 32'(HALF_CYC - 1))
    begin
      cnt_q <= 32'h0000_0000;
      wave_q <= ~wave_q;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  chk_div_bound: assert property (@(posedge mclk) disable iff (rst)
    cnt_q < 32'(HALF_CYC))
    else $error("Blink divider counter out of range");
endmodule

// ===== rtl/dli_pkg.sv
package dli_pkg;
  // ----------------------------------------------------------------
  // Register map (word-aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CODE = 4'h0; // Progress code, RW
  localparam logic [3:0] ADDR_FLT = 4'h4; // Fault condition inputs, RW
  localparam logic [3:0] ADDR_STAT = 4'h8; // Lamp state, RO
  localparam logic [3:0] ADDR_MGMT = 4'hC; // Management controller flags, RW

  // ----------------------------------------------------------------
  // Field positions in the fault register
  // ----------------------------------------------------------------
  localparam int FLT_WARN_LSB = 0; // Non-fatal alarms, 6 bits
  localparam int FLT_WARN_W = 6;
  localparam int FLT_FATAL_LSB = 8; // Fatal alarms, 13 bits
  localparam int FLT_FATAL_W = 13;
  localparam int FLT_DEGR_LSB = 24; // Degraded conditions, 4 bits
  localparam int FLT_DEGR_W = 4;
  localparam int FLT_HEALTHY_BIT = 31; // System powered and running

  // Management controller register bits
  localparam int MGMT_BOOTLD_BIT = 0; // Bootloader stage active
  localparam int MGMT_MEMFAIL_BIT = 1; // Controller memory test failed
  localparam int MGMT_IMGBAD_BIT = 2; // Both bootloader images bad

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_RST = 8'h00;
  localparam logic [31:0] FLT_RST = 32'h0000_0000;
  localparam logic [2:0] MGMT_RST = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 40_000_000;
  localparam longint SLOW_BLINK_HZ = 1; // About 1 Hz status blink
  localparam longint FAST_BLINK_HZ = 3; // 3 Hz identify blink
  // Half periods in clock cycles (rounded down)
  localparam int SLOW_HALF_CYC = int'(CLK_HZ / (2 * SLOW_BLINK_HZ));
  localparam int FAST_HALF_CYC = int'(CLK_HZ / (2 * FAST_BLINK_HZ));

  // ----------------------------------------------------------------
  // Status lamp states, least severe first
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    DLI_ST_OFF = 5'b0_0001,
    DLI_ST_GREEN = 5'b0_0010,
    DLI_ST_GBLINK = 5'b0_0100,
    DLI_ST_ABLINK = 5'b0_1000,
    DLI_ST_AMBER = 5'b1_0000
  } dli_state_e;
endpackage

// ===== rtl/dli_severity.sv
// Picks the most severe active condition for the status lamp
module dli_severity (
  input wire logic any_fatal,
  input wire logic any_warn,
  input wire logic any_degr,
  input wire logic healthy,
  output dli_pkg::dli_state_e sel_state
);
  // Priority chain: solid amber, amber blink, green blink, solid green
  always_comb
  begin
    if (any_fatal)
      sel_state = dli_pkg::DLI_ST_AMBER;
    else if (any_warn)
      sel_state = dli_pkg::DLI_ST_ABLINK;
    else if (any_degr)
      sel_state = dli_pkg::DLI_ST_GBLINK;
    else if (healthy)
      sel_state = dli_pkg::DLI_ST_GREEN;
    else
      sel_state = dli_pkg::DLI_ST_OFF;
  end
endmodule

// ===== rtl/dli_top.sv
// Behaviour
// - Eight progress lamps show one code
// - Upper nibble drives amber lamps 4 to 7
// - Lower nibble drives green lamps 0 to 3
// - Bit one lights lamp, no inversion
// - Lamps hold last code until rewritten
// - Code ACh lights lamps 7,5,3,2
// - Non-fatal alarms blink amber at 1 Hz
// - Correctable errors without redundancy blink amber
// - Fatal alarms give solid amber
// - Power fault or uncorrectable memory: amber
// - Processor init mismatch gives solid amber
// - Controller memory/image fail: amber plus blue
// - Bootloader stage blinks identify lamp 3 Hz
// - Watchdog, config error, backplane: degraded
// - Degraded shows green blinking at 1 Hz
// - Healthy solid green, powered down off
//
// Local design decisions: the Avalon-MM register port and the register addresses.
module dli_top #(
  parameter int SLOW_HALF = dli_pkg::SLOW_HALF_CYC, // 1 Hz half period
  parameter int FAST_HALF = dli_pkg::FAST_HALF_CYC // 3 Hz half period
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [3:0] amber_progress_lamp_q,
  output logic [3:0] green_progress_lamp_q,
  output logic status_green_q,
  output logic status_amber_q,
  output logic chassis_identify_lamp_q
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (FAST_HALF >= SLOW_HALF) begin : g_chk
    $error("dli_top: fast blink must be quicker than slow blink");
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] code_q; // Last written progress code
  logic [31:0] flt_q; // Fault condition flags
  logic [2:0] mgmt_q; // Management controller flags
  logic ack_q; // Access done, drops waitrequest
  logic slow_wave; // 1 Hz square wave
  logic fast_wave; // 3 Hz square wave
  dli_pkg::dli_state_e sel_state; // Chosen lamp state
  dli_pkg::dli_state_e state_q; // Registered lamp state
  logic any_fatal;
  logic any_warn;
  logic any_degr;
  logic mgmt_fatal;
  logic [31:0] wmask; // Byte-lane write mask
  logic acc; // Access pending this cycle

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign acc = (avs_read | avs_write) & ~ack_q;

  // Expand byte enables into a bit mask
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      wmask[8*i +: 8] = {8{avs_byteenable[i]}};
  end

  // One wait cycle per access: answer on the second edge
  always_ff @(posedge mclk)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= acc;
  end

  // Waitrequest from its own flop; low only in the acknowledging cycle
  always_ff @(posedge mclk)
  begin
    if (rst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~acc; // Complement of ack_q, but straight off a flop
  end

  // Progress code write; it stays until rewritten
  always_ff @(posedge mclk)
  begin
    if (rst)
      code_q <= dli_pkg::CODE_RST;
    else if (avs_write & ack_q & (avs_address == dli_pkg::ADDR_CODE) & avs_byteenable[0])
      code_q <= avs_writedata[7:0];
  end

  // Fault register write, masked per byte lane
  always_ff @(posedge mclk)
  begin
    if (rst)
      flt_q <= dli_pkg::FLT_RST;
    else if (avs_write & ack_q & (avs_address == dli_pkg::ADDR_FLT))
      flt_q <= (flt_q & ~wmask) | (avs_writedata & wmask);
  end

  // Management controller flags
  always_ff @(posedge mclk)
  begin
    if (rst)
      mgmt_q <= dli_pkg::MGMT_RST;
    else if (avs_write & ack_q & (avs_address == dli_pkg::ADDR_MGMT) & avs_byteenable[0])
      mgmt_q <= avs_writedata[2:0];
  end

  // Read data registered; unmapped addresses read zero
  always_ff @(posedge mclk)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_q)
    begin
      case (avs_address)
        dli_pkg::ADDR_CODE: avs_readdata <= {24'h00_0000, code_q};
        dli_pkg::ADDR_FLT: avs_readdata <= flt_q;
        dli_pkg::ADDR_STAT:
          avs_readdata <= {24'h00_0000, chassis_identify_lamp_q, status_amber_q,
                           status_green_q, state_q};
        dli_pkg::ADDR_MGMT: avs_readdata <= {29'h0000_0000, mgmt_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Progress lamps
  // ----------------------------------------------------------------
  // Straight bit copy: upper nibble amber, lower nibble green
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      amber_progress_lamp_q <= 4'h0;
      green_progress_lamp_q <= 4'h0;
    end
    else
    begin
      amber_progress_lamp_q <= code_q[7:4];
      green_progress_lamp_q <= code_q[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Blink generators
  // ----------------------------------------------------------------
  dli_blink_div #(
    .HALF_CYC(SLOW_HALF)
  ) u_slow (
    .mclk(mclk),
    .rst(rst),
    .wave_q(slow_wave)
  );

  dli_blink_div #(
    .HALF_CYC(FAST_HALF)
  ) u_fast (
    .mclk(mclk),
    .rst(rst),
    .wave_q(fast_wave)
  );

  // ----------------------------------------------------------------
  // Severity
  // ----------------------------------------------------------------
  // Firmware gathers monitor alarms into these groups
  assign any_warn = |flt_q[dli_pkg::FLT_WARN_LSB +: dli_pkg::FLT_WARN_W];
  assign mgmt_fatal = mgmt_q[dli_pkg::MGMT_MEMFAIL_BIT] | mgmt_q[dli_pkg::MGMT_IMGBAD_BIT];
  assign any_fatal = (|flt_q[dli_pkg::FLT_FATAL_LSB +: dli_pkg::FLT_FATAL_W])
                     | mgmt_fatal;
  // Bootloader stage counts as degraded too
  assign any_degr = (|flt_q[dli_pkg::FLT_DEGR_LSB +: dli_pkg::FLT_DEGR_W])
                    | mgmt_q[dli_pkg::MGMT_BOOTLD_BIT];

  dli_severity u_sev (
    .any_fatal(any_fatal),
    .any_warn(any_warn),
    .any_degr(any_degr),
    .healthy(flt_q[dli_pkg::FLT_HEALTHY_BIT]),
    .sel_state(sel_state)
  );

  // Registered state keeps lamps glitch free
  always_ff @(posedge mclk)
  begin
    if (rst)
      state_q <= dli_pkg::DLI_ST_OFF;
    else
      state_q <= sel_state;
  end

  // ----------------------------------------------------------------
  // Status and identify lamps
  // ----------------------------------------------------------------
  // Colour and cadence from the registered state
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      status_green_q <= 1'b0;
      status_amber_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        dli_pkg::DLI_ST_AMBER:
        begin
          status_green_q <= 1'b0;
          status_amber_q <= 1'b1;
        end
        dli_pkg::DLI_ST_ABLINK:
        begin
          status_green_q <= 1'b0;
          status_amber_q <= slow_wave;
        end
        dli_pkg::DLI_ST_GBLINK:
        begin
          status_green_q <= slow_wave;
          status_amber_q <= 1'b0;
        end
        dli_pkg::DLI_ST_GREEN:
        begin
          status_green_q <= 1'b1;
          status_amber_q <= 1'b0;
        end
        default:
        begin
          status_green_q <= 1'b0;
          status_amber_q <= 1'b0;
        end
      endcase
    end
  end

  // Identify lamp: solid on failure, fast blink in bootloader stage
  always_ff @(posedge mclk)
  begin
    if (rst)
      chassis_identify_lamp_q <= 1'b0;
    else if (mgmt_fatal)
      chassis_identify_lamp_q <= 1'b1;
    else if (mgmt_q[dli_pkg::MGMT_BOOTLD_BIT])
      chassis_identify_lamp_q <= fast_wave;
    else
      chassis_identify_lamp_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_lamp_code: assert property (@(posedge mclk) disable iff (rst)
    ##1 {amber_progress_lamp_q, green_progress_lamp_q} == $past(code_q))
    else $error("Progress lamps differ from code");
  chk_code_ac: assert property (@(posedge mclk) disable iff (rst)
    code_q == 8'hAC |=> {amber_progress_lamp_q, green_progress_lamp_q} == 8'b1010_1100)
    else $error("Code AC shows wrong lamps");
  chk_code_hold: assert property (@(posedge mclk) disable iff (rst)
    !(avs_write & ack_q) |=> $stable(code_q))
    else $error("Code changed without a write");
  chk_fatal_amber: assert property (@(posedge mclk) disable iff (rst)
    any_fatal ##1 any_fatal |=> status_amber_q && !status_green_q)
    else $error("Fatal not solid amber");
  chk_warn_blink: assert property (@(posedge mclk) disable iff (rst)
    (any_warn && !any_fatal) ##1 (any_warn && !any_fatal)
    |=> status_amber_q == $past(slow_wave) && !status_green_q)
    else $error("Warning not amber blink");
  chk_degr_blink: assert property (@(posedge mclk) disable iff (rst)
    state_q == dli_pkg::DLI_ST_GBLINK |=> status_green_q == $past(slow_wave) && !status_amber_q)
    else $error("Degraded not green blink");
  chk_off_dark: assert property (@(posedge mclk) disable iff (rst)
    state_q == dli_pkg::DLI_ST_OFF |=> !status_green_q && !status_amber_q)
    else $error("Lamp lit while off");
  chk_ident_solid: assert property (@(posedge mclk) disable iff (rst)
    mgmt_fatal |=> chassis_identify_lamp_q)
    else $error("Identify lamp not solid");
  chk_boot_blink: assert property (@(posedge mclk) disable iff (rst)
    mgmt_q[dli_pkg::MGMT_BOOTLD_BIT] && !mgmt_fatal
    |=> chassis_identify_lamp_q == $past(fast_wave))
    else $error("Identify lamp not blinking in bootloader stage");
  chk_wait_one: assert property (@(posedge mclk) disable iff (rst)
    (avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Waitrequest held too long");

  cov_fatal: cover property (@(posedge mclk) disable iff (rst) state_q == dli_pkg::DLI_ST_AMBER);
  cov_warn: cover property (@(posedge mclk) disable iff (rst) state_q == dli_pkg::DLI_ST_ABLINK);
  cov_degr: cover property (@(posedge mclk) disable iff (rst) state_q == dli_pkg::DLI_ST_GBLINK);
  cov_boot: cover property (@(posedge mclk) disable iff (rst) $rose(chassis_identify_lamp_q));
endmodule
